// ===== include/sbdsa_alu_if.sv
/*
  Operand and result bundle between the core and its arithmetic unit.
  Assumes the unit is purely combinational.
*/
`timescale 1ns/1ps
interface sbdsa_alu_if;
  logic [7:0] opA;
  logic [7:0] opB;
  logic carryIn;
  logic chainIn;
  logic decMode;
  logic [7:0] result;
  logic carryOut;
  logic halfOut;
  logic rangeOut;
  logic signOut;
  logic chainOut;
  logic nullOut;

  modport core (
    output opA, opB, carryIn, chainIn, decMode,
    input result, carryOut, halfOut, rangeOut, signOut, chainOut, nullOut
  );
  modport unit (
    input opA, opB, carryIn, chainIn, decMode,
    output result, carryOut, halfOut, rangeOut, signOut, chainOut, nullOut
  );
endinterface

// ===== include/sbdsa_pkg.sv
/*
  Constants and types shared by the subtract / decrement-skip datapath.
  Assumes an 8-bit data path and a two-address software port.
*/
package sbdsa_pkg;
  // ----------------------------------------
  // Widths and software port map
  // ----------------------------------------
  localparam int DATA_W = 8;
  localparam int ADDR_W = 2;
  localparam logic [1:0] ADDR_WORK = 2'h0;
  localparam logic [1:0] ADDR_STATUS = 2'h1;

  // ----------------------------------------
  // Reset values and constants
  // ----------------------------------------
  localparam logic [7:0] WORK_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] STATUS_MASK = 8'h3F;
  localparam logic [7:0] DEC_STEP = 8'h01;
  localparam logic [7:0] NULL_VALUE = 8'h00;

  // ----------------------------------------
  // Status field positions
  // ----------------------------------------
  localparam int BIT_CARRY = 0;
  localparam int BIT_HALF = 1;
  localparam int BIT_NULL = 2;
  localparam int BIT_RANGE = 3;
  localparam int BIT_SIGN = 4;
  localparam int BIT_CHAIN = 5;

  // ----------------------------------------
  // Operations and sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    subtract_with_borrow_op = 3'h0,
    subtract_with_borrow_imm_op = 3'h1,
    subtract_with_borrow_to_memory_op = 3'h2,
    dec_skip_if_null_op = 3'h3,
    dec_to_work_skip_op = 3'h4
  } sbdsa_op_type;

  typedef enum logic {
    SEQ_RUN = 1'b0,
    SEQ_FILL = 1'b1
  } sbdsa_seq_type;
endpackage

// ===== src/sbdsa_arith.sv
/*
  Combinational subtract-with-borrow and decrement unit with flag logic.
  Assumes the core registers every result it keeps.
*/
`timescale 1ns/1ps
module sbdsa_arith (
  // Operands in, result out
  sbdsa_alu_if.unit alu
);
  import sbdsa_pkg::*;

  logic [8:0] fullSum;
  logic [4:0] lowSum;

  // ----------------------------------------
  // Subtract as add of complement plus carry
  // ----------------------------------------
  always_comb begin
    fullSum = {1'b0, alu.opA} + {1'b0, ~alu.opB} + {8'h00, alu.carryIn};
    lowSum = {1'b0, alu.opA[3:0]} + {1'b0, ~alu.opB[3:0]} + {4'h0, alu.carryIn};
    if (alu.decMode) begin
      alu.result = alu.opA - DEC_STEP;
    end else begin
      alu.result = fullSum[7:0];
    end
    alu.nullOut = (alu.result == NULL_VALUE);
    alu.carryOut = fullSum[8];
    alu.halfOut = lowSum[4];
    alu.rangeOut = (alu.opA[7] != alu.opB[7]) && (fullSum[7] != alu.opA[7]);
    alu.signOut = alu.rangeOut ^ fullSum[7];
    alu.chainOut = alu.nullOut && alu.chainIn;
  end
endmodule

// ===== src/sbdsa_core.sv
/*
  Subtract-with-borrow and decrement-and-skip datapath slice of an
  8-bit core: working register, status flags, memory write-back and
  skip sequencing.
  Assumes the instruction sequencer issues one operation per cycle
  while opReady is high and supplies the memory operand in that cycle.
*/
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/1ps

// Function
// - Memory form: work minus operand minus borrow
// - Immediate form: same, result into work
// - Write-back form: difference goes to memory
// - Carry clear if negative, else set
// - Subtracts update six status flags
// - Decrement operand; skip next when zero
// - Taken skip inserts one dummy cycle
// - Nonzero result: no skip, continue
// - Work variant: result to work, memory untouched
module sbdsa_core (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Instruction issue
  input wire logic opValid,
  input wire sbdsa_pkg::sbdsa_op_type opCode,
  input wire logic [7:0] memData,
  input wire logic [7:0] immData,
  output logic opReady,
  // Memory write-back and skip
  output logic memWrEn,
  output logic [7:0] memWrData,
  output logic skipTaken,
  output logic dummyCycle,
  // Architectural state
  output logic [7:0] workingRegister,
  output logic [7:0] statusFlags,
  // Software port
  input wire logic [sbdsa_pkg::ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData
);
  import sbdsa_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  sbdsa_alu_if alu ();

  logic opTaken;
  logic subTaken;
  logic decTaken;
  logic [7:0] workingRegister_reg;
  logic [7:0] workingRegister_next;
  logic [7:0] status_reg;
  logic [7:0] status_next;
  logic memWrEn_reg;
  logic memWrEn_next;
  logic [7:0] memWrData_reg;
  logic [7:0] memWrData_next;
  logic skipTaken_reg;
  logic skipTaken_next;
  sbdsa_seq_type seq_reg;
  sbdsa_seq_type seq_next;

  // ----------------------------------------
  // Issue decode
  // ----------------------------------------
  // Operations are taken only outside the dummy cycle
  assign opReady = (seq_reg == SEQ_RUN);
  assign opTaken = opValid && opReady;
  assign subTaken = opTaken && (opCode == subtract_with_borrow_op
    || opCode == subtract_with_borrow_imm_op
    || opCode == subtract_with_borrow_to_memory_op);
  assign decTaken = opTaken && (opCode == dec_skip_if_null_op
    || opCode == dec_to_work_skip_op);

  // Operand steering into the arithmetic unit
  always_comb begin
    alu.decMode = decTaken;
    alu.carryIn = status_reg[BIT_CARRY];
    alu.chainIn = status_reg[BIT_CHAIN];
    alu.opB = memData;
    if (decTaken) begin
      alu.opA = memData;
    end else begin
      alu.opA = workingRegister_reg;
    end
    if (opCode == subtract_with_borrow_imm_op) begin
      alu.opB = immData;
    end
  end

  sbdsa_arith u_arith (
    .alu(alu)
  );

  // ----------------------------------------
  // Working register
  // ----------------------------------------
  // Executed operation wins over a software write in the same cycle
  always_comb begin
    workingRegister_next = workingRegister_reg;
    if (regWr && regAddr == ADDR_WORK) begin
      workingRegister_next = regWrData;
    end
    if (opTaken) begin
      unique case (opCode)
        subtract_with_borrow_op: workingRegister_next = alu.result;
        subtract_with_borrow_imm_op: workingRegister_next = alu.result;
        dec_to_work_skip_op: workingRegister_next = alu.result;
        default: workingRegister_next = workingRegister_next;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      workingRegister_reg <= WORK_RESET;
    end else begin
      workingRegister_reg <= workingRegister_next;
    end
  end

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  // Subtracts load all six flags; decrements leave them alone
  always_comb begin
    status_next = status_reg;
    if (regWr && regAddr == ADDR_STATUS) begin
      status_next = regWrData & STATUS_MASK;
    end
    if (subTaken) begin
      status_next[BIT_CARRY] = alu.carryOut;
      status_next[BIT_HALF] = alu.halfOut;
      status_next[BIT_NULL] = alu.nullOut;
      status_next[BIT_RANGE] = alu.rangeOut;
      status_next[BIT_SIGN] = alu.signOut;
      status_next[BIT_CHAIN] = alu.chainOut;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      status_reg <= STATUS_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  // ----------------------------------------
  // Memory write-back
  // ----------------------------------------
  // One-cycle write pulse with registered data
  always_comb begin
    memWrEn_next = 1'b0;
    memWrData_next = memWrData_reg;
    if (opTaken && (opCode == subtract_with_borrow_to_memory_op
        || opCode == dec_skip_if_null_op)) begin
      memWrEn_next = 1'b1;
      memWrData_next = alu.result;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      memWrEn_reg <= 1'b0;
      memWrData_reg <= 8'h00;
    end else begin
      memWrEn_reg <= memWrEn_next;
      memWrData_reg <= memWrData_next;
    end
  end

  // ----------------------------------------
  // Skip sequencer
  // ----------------------------------------
  // A zero decrement skips and holds one dummy cycle
  always_comb begin
    skipTaken_next = decTaken && alu.nullOut;
    seq_next = seq_reg;
    unique case (seq_reg)
      SEQ_RUN: begin
        if (skipTaken_next) begin
          seq_next = SEQ_FILL;
        end
      end
      SEQ_FILL: seq_next = SEQ_RUN;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      seq_reg <= SEQ_RUN;
      skipTaken_reg <= 1'b0;
    end else begin
      seq_reg <= seq_next;
      skipTaken_reg <= skipTaken_next;
    end
  end

  // ----------------------------------------
  // Outputs and software read port
  // ----------------------------------------
  assign memWrEn = memWrEn_reg;
  assign memWrData = memWrData_reg;
  assign skipTaken = skipTaken_reg;
  assign dummyCycle = (seq_reg == SEQ_FILL);
  assign workingRegister = workingRegister_reg;
  assign statusFlags = status_reg;

  sbdsa_reg_read u_reg_read (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .regAddr(regAddr),
    .regRd(regRd),
    .workValue(workingRegister_reg),
    .statusValue(status_reg),
    .regRdData(regRdData)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  logic borrowIn;
  logic [8:0] needed;
  logic [4:0] nibbleNeeded;
  logic [7:0] subResult;
  assign borrowIn = ~status_reg[BIT_CARRY];
  assign needed = {1'b0, alu.opB} + {8'h00, borrowIn};
  // Low nibble borrow demand, and the result wherever the last subtract put it
  assign nibbleNeeded = {1'b0, alu.opB[3:0]} + {4'h0, borrowIn};
  assign subResult = memWrEn ? memWrData : workingRegister_reg;

  sequence s_skipIssue;
    decTaken && memData == DEC_STEP;
  endsequence

  sequence s_fillThenRun;
    skipTaken && dummyCycle && !opReady ##1 !dummyCycle && opReady && !skipTaken;
  endsequence

  a_sub_mem_work: assert property (
    subTaken && opCode == subtract_with_borrow_op |=>
      workingRegister_reg == 8'($past(workingRegister_reg) - $past(memData)
        - {7'h00, $past(borrowIn)}))
    else $error("memory subtract result wrong");

  a_sub_imm_work: assert property (
    subTaken && opCode == subtract_with_borrow_imm_op |=>
      workingRegister_reg == 8'($past(workingRegister_reg) - $past(immData)
        - {7'h00, $past(borrowIn)}))
    else $error("immediate subtract result wrong");

  a_sub_to_mem: assert property (
    subTaken && opCode == subtract_with_borrow_to_memory_op |=>
      memWrEn && (workingRegister_reg == $past(workingRegister_reg) || $past(regWr))
      && memWrData == 8'($past(workingRegister_reg) - $past(memData)
        - {7'h00, $past(borrowIn)}) ##1 (!memWrEn || $past(opTaken)))
    else $error("write-back subtract wrong");

  a_carry_sign: assert property (
    subTaken |=> status_reg[BIT_CARRY]
      == ({1'b0, $past(workingRegister_reg)} >= $past(needed)))
    else $error("carry does not match sign of difference");

  a_chain_null: assert property (
    subTaken |=> status_reg[BIT_CHAIN]
      == ($past(status_reg[BIT_CHAIN]) && status_reg[BIT_NULL]))
    else $error("chained zero flag wrong");

  a_dec_skip: assert property (
    s_skipIssue |=> skipTaken && (memWrEn || workingRegister_reg == NULL_VALUE))
    else $error("zero decrement did not skip");

  a_skip_fill: assert property (
    s_skipIssue |=> s_fillThenRun)
    else $error("skip did not take exactly one dummy cycle");

  a_no_skip: assert property (
    decTaken && memData != DEC_STEP |=> !skipTaken && opReady)
    else $error("nonzero decrement skipped");

  a_dec_work: assert property (
    decTaken && opCode == dec_to_work_skip_op |=>
      !memWrEn && workingRegister_reg == 8'($past(memData) - DEC_STEP)
      && (status_reg == $past(status_reg) || $past(regWr)))
    else $error("decrement to work wrong");

  a_zero_range: assert property (
    subTaken |=> status_reg[BIT_NULL] == (subResult == NULL_VALUE)
      && status_reg[BIT_RANGE] == ($past(alu.opA[7]) != $past(alu.opB[7])
        && subResult[7] != $past(alu.opA[7])))
    else $error("zero or overflow flag wrong");

  a_sign_flag: assert property (
    subTaken |=> status_reg[BIT_SIGN] == (status_reg[BIT_RANGE] ^ subResult[7]))
    else $error("signed result flag wrong");

  a_half_borrow: assert property (
    subTaken |=> status_reg[BIT_HALF]
      == ({1'b0, $past(alu.opA[3:0])} >= $past(nibbleNeeded)))
    else $error("nibble borrow flag wrong");

  a_dummy_refuse: assert property (
    dummyCycle |-> !opTaken ##1 !dummyCycle)
    else $error("operation taken during dummy cycle");
endmodule

// ===== src/sbdsa_reg_read.sv
/*
  Read side of the software port: registered read data.
  Assumes the read strobe is one cycle and data are used the next cycle.
*/
`timescale 1ns/1ps
module sbdsa_reg_read (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Read request
  input wire logic [sbdsa_pkg::ADDR_W-1:0] regAddr,
  input wire logic regRd,
  // Values to show
  input wire logic [7:0] workValue,
  input wire logic [7:0] statusValue,
  // Read answer
  output logic [7:0] regRdData
);
  import sbdsa_pkg::*;

  logic [7:0] rdData_reg;
  logic [7:0] rdData_next;

  // ----------------------------------------
  // Address decode, zero when idle or unmapped
  // ----------------------------------------
  always_comb begin
    rdData_next = 8'h00;
    if (regRd) begin
      unique case (regAddr)
        ADDR_WORK: rdData_next = workValue;
        ADDR_STATUS: rdData_next = statusValue & STATUS_MASK;
        default: rdData_next = 8'h00;
      endcase
    end
  end

  // Read data register
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdData_reg <= 8'h00;
    end else begin
      rdData_reg <= rdData_next;
    end
  end

  assign regRdData = rdData_reg;
endmodule

// ===== testbench/sbdsa_core_tb_top.sv
/*
  Self-checking bench for the subtract / decrement-skip datapath.
  Assumes the memory model above and the port timing of the core.
*/
`timescale 1ns/1ps
`define CHK(g, e, m) begin nTests++; if ((g) !== (e)) begin numErrors++; \
  $display("[FAIL] %0t %s", $time, m); end end
module sbdsa_core_tb_top;
  import sbdsa_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic opValid = 1'b0;
  sbdsa_op_type opCode = subtract_with_borrow_op;
  logic [7:0] memData, immData = 8'h00, memWrData, workingRegister, statusFlags;
  logic opReady, memWrEn, skipTaken, dummyCycle, regWr = 1'b0, regRd = 1'b0;
  logic [1:0] regAddr = 2'h0, memAddr = 2'h0;
  logic [7:0] regWrData = 8'h00, regRdData;
  int numErrors = 0;
  int nTests = 0;
  int cycles = 0;

  sbdsa_core uut (.clk_sys(clk_sys), .rstn(rstn), .opValid(opValid), .opCode(opCode),
    .memData(memData), .immData(immData), .opReady(opReady), .memWrEn(memWrEn),
    .memWrData(memWrData), .skipTaken(skipTaken), .dummyCycle(dummyCycle),
    .workingRegister(workingRegister), .statusFlags(statusFlags), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData));
  sbdsa_mem_model pm (.clk_sys(clk_sys), .opValid(opValid), .opReady(opReady),
    .memAddr(memAddr), .memData(memData), .memWrEn(memWrEn), .memWrData(memWrData));

  // ----------------------------------------
  // Clock, timeout and verdict
  // ----------------------------------------
  always #50 clk_sys = ~clk_sys;

  // Cut a hang short
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      numErrors++;
      finishTest();
    end
  end

  task automatic finishTest();
    if (numErrors == 0 && nTests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------
  // Bus cycles and expected arithmetic
  // ----------------------------------------
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regWr <= 1'b1; regAddr <= a; regWrData <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    regRd <= 1'b1; regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 `CHK(regRdData, e, "read data")
    @(posedge clk_sys);
    #1 `CHK(regRdData, 8'h00, "read data not cleared")
  endtask

  // Result in the upper byte, status in the lower byte
  function automatic logic [15:0] calc(input logic [7:0] a, b, input logic ci, ch);
    int br;
    int s;
    logic [7:0] r;
    logic ov;
    br = ci ? 0 : 1;
    s = $signed(a) - $signed(b) - br;
    r = 8'(int'(a) - int'(b) - br);
    ov = (s < -128) || (s > 127);
    calc = {r, 2'h0, (r == 8'h00) & ch, ov ^ r[7], ov, r == 8'h00,
      int'(a[3:0]) >= int'(b[3:0]) + br, int'(a) >= int'(b) + br};
  endfunction

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic sub(input sbdsa_op_type c, input logic [7:0] w, f, b);
    logic [15:0] e;
    wr(ADDR_WORK, w);
    wr(ADDR_STATUS, f);
    pm.mem[1] = (c == subtract_with_borrow_imm_op) ? ~b : b;
    e = calc(w, b, f[0], f[5]);
    @(posedge clk_sys);
    opValid <= 1'b1; opCode <= c; memAddr <= 2'h1; immData <= b;
    @(posedge clk_sys);
    opValid <= 1'b0;
    #1 `CHK(statusFlags, e[7:0], "status after subtract")
    if (c == subtract_with_borrow_to_memory_op) begin
      `CHK(memWrEn, 1'b1, "no write-back")
      `CHK(memWrData, e[15:8], "write-back value")
      `CHK(workingRegister, w, "work changed")
    end else begin
      `CHK(workingRegister, e[15:8], "work after subtract")
      `CHK(memWrEn, 1'b0, "stray write-back")
    end
    rd(ADDR_STATUS, e[7:0]);
  endtask

  // Decrement; on a skip an op is offered in the dummy cycle and must be refused
  task automatic dec(input sbdsa_op_type c, input logic [7:0] m);
    logic z;
    logic toMem;
    logic [7:0] w0, f0, ew;
    z = (m == 8'h01);
    toMem = (c == dec_skip_if_null_op);
    w0 = workingRegister;
    f0 = statusFlags;
    ew = toMem ? w0 : m - 8'h01;
    pm.mem[2] = m;
    @(posedge clk_sys);
    opValid <= 1'b1; opCode <= c; memAddr <= 2'h2;
    @(posedge clk_sys);
    opValid <= z; opCode <= subtract_with_borrow_imm_op; immData <= 8'h11;
    #1 `CHK(skipTaken, z, "skip pulse")
    `CHK(dummyCycle, z, "dummy cycle")
    `CHK(opReady, !z, "ready in dummy cycle")
    `CHK(memWrEn, toMem, "write-back enable")
    if (toMem) `CHK(memWrData, m - 8'h01, "decremented value")
    `CHK(workingRegister, ew, "work after decrement")
    `CHK(statusFlags, f0, "status touched by decrement")
    @(posedge clk_sys);
    opValid <= 1'b0;
    #1 `CHK(skipTaken, 1'b0, "skip longer than one cycle")
    `CHK(opReady, 1'b1, "ready not back")
    `CHK(workingRegister, ew, "op taken in dummy cycle")
    `CHK(pm.mem[2], toMem ? m - 8'h01 : m, "memory cell")
  endtask

  task automatic regs();
    `CHK(workingRegister, 8'h00, "work reset")
    `CHK(statusFlags, 8'h00, "status reset")
    `CHK(opReady, 1'b1, "ready reset")
    wr(ADDR_STATUS, 8'hFF);
    rd(ADDR_STATUS, 8'h3F);
    wr(ADDR_WORK, 8'h5A);
    wr(2'h3, 8'hAA);
    rd(2'h2, 8'h00);
    rd(2'h3, 8'h00);
    rd(ADDR_WORK, 8'h5A);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    regs();
    sub(subtract_with_borrow_op, 8'h10, 8'h01, 8'h05);
    sub(subtract_with_borrow_op, 8'h10, 8'h00, 8'h05);
    sub(subtract_with_borrow_imm_op, 8'h05, 8'h01, 8'h06);
    sub(subtract_with_borrow_imm_op, 8'h80, 8'h01, 8'h01);
    sub(subtract_with_borrow_op, 8'h05, 8'h21, 8'h05);
    sub(subtract_with_borrow_to_memory_op, 8'h30, 8'h01, 8'h0F);
    sub(subtract_with_borrow_to_memory_op, 8'h00, 8'h00, 8'h00);
    dec(dec_skip_if_null_op, 8'h01);
    dec(dec_skip_if_null_op, 8'h05);
    dec(dec_to_work_skip_op, 8'h01);
    dec(dec_to_work_skip_op, 8'h00);
    finishTest();
  end
endmodule

// ===== testbench/sbdsa_mem_model.sv
/*
  Behavioural data memory with the sequencer's operand side, facing the core.
  Assumes the bench presets cells directly and issues one op per cycle.
*/
`timescale 1ns/1ps
module sbdsa_mem_model (
  // Clock
  input wire logic clk_sys,
  // Issue side
  input wire logic opValid,
  input wire logic opReady,
  input wire logic [1:0] memAddr,
  output logic [7:0] memData,
  // Write-back from the core
  input wire logic memWrEn,
  input wire logic [7:0] memWrData
);
  logic [7:0] mem [4];
  logic [1:0] wrAddr;
  logic [7:0] lastData;

  initial begin
    mem = '{8'h00, 8'h00, 8'h00, 8'h00};
    wrAddr = 2'h0;
    lastData = 8'h00;
  end

  // Operand lines carry junk while nothing is issued
  assign memData = opValid ? mem[memAddr] : ~lastData;

  // Remember the taken op's address and store its write-back
  always @(posedge clk_sys) begin
    if (opValid) lastData <= mem[memAddr];
    if (opValid && opReady) wrAddr <= memAddr;
    if (memWrEn) mem[wrAddr] <= memWrData;
  end
endmodule
